/* hw/dpram_host.sv */
// Host-side port controller for one port of the dual-port RAM
`timescale 1ns/10ps
`default_nettype none
`include "dpram_defs.svh"
module dpram_host #(
  parameter int DW = `DPRAM_DATA_W,
  parameter int AW = `DPRAM_ADDR_W
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire dpram_pkg::dpram_req_t req,
  output logic rsp_valid,
  output logic [DW-1:0] rsp_data,
  output logic rsp_token_owned,
  output logic [AW-1:0] addr,
  output dpram_pkg::dpram_ctl_t ctl,
  input wire logic [DW-1:0] data_in,
  output logic [DW-1:0] data_out,
  output logic data_oe,
  input wire logic busy_n,
  input wire logic mailbox_flag_n,
  output logic mailbox_pending
);
  localparam logic [3:0] C_SCE = 4'(`DPRAM_CYC_MIN(`DPRAM_T_SCE_NS));
  localparam logic [3:0] C_SOP = 4'(`DPRAM_CYC_MIN(`DPRAM_T_SOP_NS));
  localparam logic [3:0] C_SWRD = 4'(`DPRAM_CYC_MIN(`DPRAM_T_SWRD_NS));
  localparam logic [3:0] C_WH = 4'(`DPRAM_CYC_MIN(`DPRAM_T_WH_NS));
  localparam logic [3:0] C_ACC = 4'(`DPRAM_CYC_MIN(`DPRAM_T_ACC_NS) + 1);
  // Busy settle plus synchroniser latency before the write strobe
  localparam logic [3:0] C_BSY =
    4'(`DPRAM_CYC_MIN(`DPRAM_T_BLA_NS) + `DPRAM_SYNC_STAGES);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_STROBE = 3'b010,
    ST_READ = 3'b011,
    ST_RECOVER = 3'b100
  } dpram_st_t;

  dpram_st_t st_r, st_nxt;
  dpram_pkg::dpram_req_t cur_r, cur_nxt;
  dpram_pkg::dpram_ctl_t ctl_r, ctl_nxt;
  logic oe_r, oe_nxt;
  logic rsp_valid_r, rsp_valid_nxt;
  logic [DW-1:0] rsp_data_r, rsp_data_nxt;
  logic last_token_wr_r, last_token_wr_nxt;
  logic busy_s1_r, busy_s2_r, flag_s1_r, flag_s2_r;
  logic [DW-1:0] din_s1_r, din_s2_r;
  logic load;
  logic [3:0] load_val;
  logic tmr_done;

  dpram_cnt #(.W(4)) u_tmr (
    .mclk(mclk),
    .rst_n(rst_n),
    .load(load),
    .value(load_val),
    .done(tmr_done)
  );

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      busy_s1_r <= 1'b1;
      busy_s2_r <= 1'b1;
      flag_s1_r <= 1'b1;
      flag_s2_r <= 1'b1;
      din_s1_r <= '0;
      din_s2_r <= '0;
    end else begin
      busy_s1_r <= busy_n;
      busy_s2_r <= busy_s1_r;
      flag_s1_r <= mailbox_flag_n;
      flag_s2_r <= flag_s1_r;
      din_s1_r <= data_in;
      din_s2_r <= din_s1_r;
    end
  end

  always_comb begin
    st_nxt = st_r;
    cur_nxt = cur_r;
    ctl_nxt = ctl_r;
    oe_nxt = oe_r;
    rsp_valid_nxt = 1'b0;
    rsp_data_nxt = rsp_data_r;
    last_token_wr_nxt = last_token_wr_r;
    load = 1'b0;
    load_val = 4'h0;
    unique case (st_r)
      ST_IDLE: begin
        if (req_valid && tmr_done) begin
          cur_nxt = req;
          if (req.token && req.write) begin
            cur_nxt.wdata[`DPRAM_BIT_TOKEN] = 1'b0;
          end
          ctl_nxt.chip_select_n = req.token;
          ctl_nxt.token_select_n = !req.token;
          ctl_nxt.output_enable_n = req.write;
          oe_nxt = 1'b0;
          load = 1'b1;
          load_val = C_BSY;
          st_nxt = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (cur_r.write) begin
          if (!busy_s2_r) begin
            load = 1'b1;
            load_val = C_WH;
          end else if (tmr_done) begin
            ctl_nxt.write_strobe_n = 1'b0;
            oe_nxt = 1'b1;
            load = 1'b1;
            load_val = C_SCE;
            st_nxt = ST_STROBE;
          end
        end else begin
          load = 1'b1;
          load_val = C_ACC;
          st_nxt = ST_READ;
        end
      end
      ST_STROBE: begin
        if (!busy_s2_r) begin
          ctl_nxt.write_strobe_n = 1'b1;
          load = 1'b1;
          load_val = C_WH;
          st_nxt = ST_SETUP;
        end else if (tmr_done) begin
          ctl_nxt.write_strobe_n = 1'b1;
          last_token_wr_nxt = cur_r.token;
          rsp_valid_nxt = 1'b1;
          load = 1'b1;
          load_val = cur_r.token ? C_SWRD : C_SOP;
          st_nxt = ST_RECOVER;
        end
      end
      ST_READ: begin
        if (tmr_done) begin
          rsp_data_nxt = din_s2_r;
          rsp_valid_nxt = 1'b1;
          last_token_wr_nxt = 1'b0;
          load = 1'b1;
          load_val = C_SOP;
          st_nxt = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        oe_nxt = 1'b0;
        ctl_nxt = '{chip_select_n: 1'b1, token_select_n: 1'b1,
                    write_strobe_n: 1'b1, output_enable_n: 1'b1};
        if (tmr_done) begin
          load = 1'b1;
          load_val = last_token_wr_r ? C_SWRD : C_SOP;
          st_nxt = ST_IDLE;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
      cur_r <= '0;
      ctl_r <= '{chip_select_n: 1'b1, token_select_n: 1'b1,
                 write_strobe_n: 1'b1, output_enable_n: 1'b1};
      oe_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_data_r <= '0;
      last_token_wr_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cur_r <= cur_nxt;
      ctl_r <= ctl_nxt;
      oe_r <= oe_nxt;
      rsp_valid_r <= rsp_valid_nxt;
      rsp_data_r <= rsp_data_nxt;
      last_token_wr_r <= last_token_wr_nxt;
    end
  end

  assign req_ready = (st_r == ST_IDLE) && tmr_done;
  assign addr = cur_r.addr;
  assign ctl = ctl_r;
  assign data_out = cur_r.wdata;
  assign data_oe = oe_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp_data = rsp_data_r;
  assign rsp_token_owned = !rsp_data_r[`DPRAM_BIT_TOKEN];
  assign mailbox_pending = !flag_s2_r;

  a_addr_stable: assert property (@(posedge mclk) disable iff (!rst_n)
    !ctl_r.write_strobe_n |=> $stable(addr)) else $error("address moved in write");
  a_no_contend: assert property (@(posedge mclk) disable iff (!rst_n)
    !ctl_r.output_enable_n |-> !oe_r) else $error("data driven while device drives");
  a_sel_excl: assert property (@(posedge mclk) disable iff (!rst_n)
    !(ctl_r.chip_select_n == 1'b0 && ctl_r.token_select_n == 1'b0))
    else $error("both selects low");
  a_sel_stable: assert property (@(posedge mclk) disable iff (!rst_n)
    !ctl_r.write_strobe_n |=> $stable(ctl_r.chip_select_n)) else $error("select moved");
  a_token_low: assert property (@(posedge mclk) disable iff (!rst_n)
    (!ctl_r.write_strobe_n && !ctl_r.token_select_n) |-> !data_out[0])
    else $error("token write not low");
  a_strobe_busy: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(ctl_r.write_strobe_n) |-> $past(busy_s2_r)) else $error("write while busy");
  a_update_gap: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(rsp_valid_r) |=> (ctl_r.token_select_n && ctl_r.chip_select_n))
    else $error("no recovery gap");
  a_recover_min: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(ctl_r.token_select_n) |-> ctl_r.token_select_n [*2]) else $error("gap short");
  a_oe_write: assert property (@(posedge mclk) disable iff (!rst_n)
    !ctl_r.write_strobe_n |-> oe_r) else $error("write without data");
  c_ram_write: cover property (@(posedge mclk) !ctl_r.write_strobe_n && !ctl_r.chip_select_n);
  c_tok_write: cover property (@(posedge mclk) !ctl_r.write_strobe_n && !ctl_r.token_select_n);
  c_read: cover property (@(posedge mclk) rsp_valid_r && !cur_r.write);
  c_busy_hold: cover property (@(posedge mclk) st_r == ST_SETUP && !busy_s2_r);
endmodule
`default_nettype wire

/* inc/dpram_defs.svh */
// Timing and field constants for the dual-port RAM port controller
`ifndef DPRAM_DEFS_SVH
`define DPRAM_DEFS_SVH
`define DPRAM_CLK_PERIOD_NS 20
`define DPRAM_T_SCE_NS 12
`define DPRAM_T_SOP_NS 10
`define DPRAM_T_SWRD_NS 5
`define DPRAM_T_WH_NS 13
`define DPRAM_T_ACC_NS 15
`define DPRAM_T_BLA_NS 15
`define DPRAM_SYNC_STAGES 2
`define DPRAM_CYC_MIN(ns) (((ns) + `DPRAM_CLK_PERIOD_NS - 1) / `DPRAM_CLK_PERIOD_NS)
`define DPRAM_DATA_W 8
`define DPRAM_ADDR_W 17
`define DPRAM_TOKEN_W 3
`define DPRAM_BIT_TOKEN 0
`endif

/* inc/dpram_pkg.sv */
// Types for the dual-port RAM port controller
`include "dpram_defs.svh"
package dpram_pkg;
  typedef struct packed {
    logic write;
    logic token;
    logic [`DPRAM_ADDR_W-1:0] addr;
    logic [`DPRAM_DATA_W-1:0] wdata;
  } dpram_req_t;
  typedef struct packed {
    logic chip_select_n;
    logic token_select_n;
    logic write_strobe_n;
    logic output_enable_n;
  } dpram_ctl_t;
endpackage

/* hw/dpram_cnt.sv */
// Cycle down-counter used for pin timing
`timescale 1ns/10ps
`default_nettype none
module dpram_cnt #(
  parameter int W = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic done
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  always_comb begin
    cnt_nxt = cnt_r;
    if (load) begin
      cnt_nxt = value;
    end else if (cnt_r != {W{1'b0}}) begin
      cnt_nxt = cnt_r - {{(W-1){1'b0}}, 1'b1};
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_r <= {W{1'b0}};
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
  assign done = (cnt_r == {W{1'b0}});
endmodule
`default_nettype wire

/* tb/dpram_dev_model.sv */
// Behavioural model of the dual-port RAM seen from one port
`timescale 1ns/10ps
`default_nettype none
module dpram_dev_model (
  input wire logic [16:0] addr,
  input wire dpram_pkg::dpram_ctl_t ctl,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  output logic [7:0] data_in,
  output logic busy_n,
  output logic mailbox_flag_n,
  input wire logic o_cs_n,
  input wire logic [16:0] o_addr,
  input wire logic o_claim,
  input wire logic o_int_n,
  output logic clash
);
  logic [7:0] mem [16];
  logic [1:0] own [8];
  logic [7:0] junk;
  logic rd_ok, arr_rd, sem_rd;
  initial begin
    junk = 8'h3C;
    clash = 1'b0;
    foreach (own[i]) own[i] = 2'h0;
  end
  always #20 junk = junk ^ 8'hA5;
  assign rd_ok = ctl.write_strobe_n && !ctl.output_enable_n;
  assign arr_rd = !ctl.chip_select_n && ctl.token_select_n && rd_ok;
  assign sem_rd = ctl.chip_select_n && !ctl.token_select_n && rd_ok;
  always_comb begin
    data_in = junk;
    if (arr_rd) data_in = mem[addr[3:0]];
    if (sem_rd) data_in = {7'h7F, own[addr[2:0]] != 2'h1};
  end
  always @(posedge ctl.write_strobe_n) begin
    if (!ctl.chip_select_n && ctl.token_select_n) mem[addr[3:0]] = data_out;
    if (ctl.chip_select_n && !ctl.token_select_n) begin
      if (!data_out[0] && own[addr[2:0]] == 2'h0) own[addr[2:0]] = 2'h1;
      else if (data_out[0] && own[addr[2:0]] == 2'h1) own[addr[2:0]] = 2'h0;
    end
  end
  always @(posedge o_claim) if (own[o_addr[2:0]] == 2'h0) own[o_addr[2:0]] = 2'h2;
  always @* if (data_oe && (arr_rd || sem_rd)) clash = 1'b1;
  assign #12 busy_n = !(!ctl.chip_select_n && !o_cs_n && addr == o_addr);
  assign #12 mailbox_flag_n = o_int_n;
endmodule
`default_nettype wire

/* tb/tb_dual_port_ram_arbitration.sv */
// Self-checking testbench for the dual-port RAM port controller
`timescale 1ns/10ps
`default_nettype none
module tb_dual_port_ram_arbitration;
  logic mclk, rst_n, req_valid, req_ready, rsp_valid, rsp_token_owned, data_oe, busy_n;
  logic mailbox_flag_n, mailbox_pending, o_cs_n, o_claim, o_int_n, clash, own;
  logic [7:0] rsp_data, data_in, data_out, rd;
  logic [16:0] addr, o_addr;
  dpram_pkg::dpram_req_t req;
  dpram_pkg::dpram_ctl_t ctl;
  int err_count, cmp_count;
  time t_rsp, t_rel;
  dpram_host DUT (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_token_owned(rsp_token_owned),
    .addr(addr), .ctl(ctl), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .busy_n(busy_n), .mailbox_flag_n(mailbox_flag_n), .mailbox_pending(mailbox_pending));
  dpram_dev_model MDL (.addr(addr), .ctl(ctl), .data_out(data_out), .data_oe(data_oe),
    .data_in(data_in), .busy_n(busy_n), .mailbox_flag_n(mailbox_flag_n), .o_cs_n(o_cs_n),
    .o_addr(o_addr), .o_claim(o_claim), .o_int_n(o_int_n), .clash(clash));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t data %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t flag %b exp %b", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic access(input logic w, input logic t, input logic [16:0] a, input logic [7:0] d);
    int i;
    @(negedge mclk);
    req = '{write: w, token: t, addr: a, wdata: d};
    req_valid = 1'b1;
    i = 0;
    while (req_ready !== 1'b1 && i < 200) begin
      @(negedge mclk);
      i++;
    end
    if (i == 200) begin
      err_count++;
      $display("[ERR] %0t request not taken", $time);
    end
    @(negedge mclk);
    req_valid = 1'b0;
    i = 0;
    while (rsp_valid !== 1'b1 && i < 200) begin
      @(negedge mclk);
      i++;
    end
    if (i == 200) begin
      err_count++;
      $display("[ERR] %0t no response", $time);
    end
    rd = rsp_data;
    own = rsp_token_owned;
    t_rsp = $time;
  endtask
  task automatic t_array();
    access(1'b1, 1'b0, 17'h00003, 8'h5A);
    access(1'b1, 1'b0, 17'h00004, 8'hC3);
    access(1'b0, 1'b0, 17'h00003, 8'h00);
    chk8(rd, 8'h5A);
    access(1'b0, 1'b0, 17'h00004, 8'h00);
    chk8(rd, 8'hC3);
  endtask
  task automatic t_token();
    access(1'b1, 1'b1, 17'h00002, 8'hFF);
    access(1'b0, 1'b1, 17'h00002, 8'h00);
    chk1(own, 1'b1);
    o_addr = 17'h00005;
    o_claim = 1'b1;
    @(negedge mclk);
    o_claim = 1'b0;
    access(1'b1, 1'b1, 17'h00005, 8'h00);
    access(1'b0, 1'b1, 17'h00005, 8'h00);
    chk1(own, 1'b0);
  endtask
  task automatic t_busy();
    o_addr = 17'h00007;
    o_cs_n = 1'b0;
    fork
      access(1'b1, 1'b0, 17'h00007, 8'h96);
      begin
        repeat (8) @(negedge mclk);
        t_rel = $time;
        o_cs_n = 1'b1;
      end
    join
    chk1(t_rsp > t_rel, 1'b1);
    access(1'b0, 1'b0, 17'h00007, 8'h00);
    chk8(rd, 8'h96);
  endtask
  task automatic t_mail();
    o_int_n = 1'b0;
    repeat (4) @(negedge mclk);
    chk1(mailbox_pending, 1'b1);
    o_int_n = 1'b1;
    repeat (4) @(negedge mclk);
    chk1(mailbox_pending, 1'b0);
  endtask
  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    o_cs_n = 1'b1;
    o_addr = '0;
    o_claim = 1'b0;
    o_int_n = 1'b1;
    err_count = 0;
    cmp_count = 0;
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    t_array();
    t_token();
    t_busy();
    t_mail();
    chk1(clash, 1'b0);
    stop_test();
  end
  initial begin
    #200000;
    err_count++;
    stop_test();
  end
endmodule
`default_nettype wire
